// file: brt_cycle_timer.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Down counter of isochronous ticks with a one-cycle expiry pulse.
// ****************************************************************
module brt_cycle_timer
    import brt_pkg::*;
#(
    parameter int W = 8
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic abort,
    input wire logic [W-1:0] load,
    input wire logic tick,
    output logic busy,
    output logic expired
);
    logic [W-1:0] cnt_reg;
    logic run_reg;
    logic expired_reg;

    // Start wins over abort so that a restart is never lost.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
            expired_reg <= 1'b0;
        end
        else
        begin
            expired_reg <= 1'b0;
            if (start)
            begin
                cnt_reg <= load;
                run_reg <= 1'b1;
            end
            else if (abort)
                run_reg <= 1'b0;
            else if (run_reg && cnt_reg == '0)
            begin
                run_reg <= 1'b0;
                expired_reg <= 1'b1;
            end
            else if (run_reg && tick)
                cnt_reg <= cnt_reg - 1'b1;
        end
    end

    assign busy = run_reg;
    assign expired = expired_reg;
endmodule // brt_cycle_timer
`default_nettype wire

// file: brt_iso_tick.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Free-running isochronous cycle tick generator.
// ****************************************************************
module brt_iso_tick
    import brt_pkg::*;
#(
    parameter int CYCLE_CLKS = BRT_ISO_CYCLE_CLKS
)
(
    input wire logic pclk,
    input wire logic presetn,
    output logic tick
);
    localparam int CNT_W = (CYCLE_CLKS > 1) ? $clog2(CYCLE_CLKS) : 1;
    localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLE_CLKS - 1);

    logic [CNT_W-1:0] cnt_reg;
    logic tick_reg;

    // Count clocks and pulse once per cycle period.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_reg <= '0;
            tick_reg <= 1'b0;
        end
        else
        begin
            tick_reg <= (cnt_reg == LAST);
            cnt_reg <= (cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
        end
    end

    assign tick = tick_reg;
endmodule // brt_iso_tick
`default_nettype wire

// file: brt_node_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Far-side nodes: bus reset results and transmit acknowledges.
// ****************************************************************
module brt_node_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go_reset,
    input wire logic [31:0] topo,
    input wire logic go_ack,
    input wire logic busy,
    output logic bus_reset_done,
    output logic [31:0] topo_out,
    output logic tx_ack_valid,
    output logic tx_ack_busy
);
    // Results hold only in the load cycle; otherwise the lines show
    // the inverse, so a block that samples them late reads garbage.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus_reset_done <= 1'b0;
            topo_out <= 32'h0;
            tx_ack_valid <= 1'b0;
            tx_ack_busy <= 1'b0;
        end
        else
        begin
            bus_reset_done <= go_reset;
            topo_out <= go_reset ? topo : ~topo;
            tx_ack_valid <= go_ack;
            tx_ack_busy <= go_ack ? busy : ~busy;
        end
    end
endmodule // brt_node_model
`default_nettype wire

// file: brt_pkg.sv
// ****************************************************************
// Constants shared by the bus reset and time limit register bank.
// ****************************************************************
package brt_pkg;

    // ************************************************************
    // Register byte offsets on the APB port.
    // ************************************************************
    localparam logic [11:0] BRT_BUS_RESET_STATUS_OFF = 12'h024;
    localparam logic [11:0] BRT_TIME_LIMITS_OFF = 12'h028;
    localparam logic [11:0] BRT_IRQ_STATUS_OFF = 12'h040;
    localparam logic [11:0] BRT_IRQ_MASK_OFF = 12'h044;

    // ************************************************************
    // Field positions; each is the register bit that holds field bit 0.
    // ************************************************************
    localparam int BRT_BUS_INDEX_LSB = 22;
    localparam int BRT_NODE_INDEX_LSB = 16;
    localparam int BRT_FAULT_LSB = 12;
    localparam int BRT_NODE_TOTAL_LSB = 6;
    localparam int BRT_RM_NODE_LSB = 0;
    localparam int BRT_WAIT_LIMIT_LSB = 16;
    localparam int BRT_RETRY_GAP_LSB = 8;
    localparam int BRT_RETRY_LIMIT_LSB = 4;
    localparam int BRT_FETCH_DELAY_LSB = 0;

    // ************************************************************
    // Values after reset.
    // ************************************************************
    localparam logic [31:0] BRT_BUS_RESET_STATUS_RST = 32'hffff003f;
    localparam logic [31:0] BRT_TIME_LIMITS_RST = 32'h032008e0;
    localparam logic [3:0] BRT_IRQ_MASK_RST = 4'h0;

    // ************************************************************
    // Self-ID check result codes; 4'h9 to 4'he are reserved.
    // ************************************************************
    localparam logic [3:0] BRT_FAULT_NONE = 4'h0;
    localparam logic [3:0] BRT_FAULT_CHILD_STATUS = 4'h1;
    localparam logic [3:0] BRT_FAULT_ID_ORDER = 4'h2;
    localparam logic [3:0] BRT_FAULT_INVERSE = 4'h3;
    localparam logic [3:0] BRT_FAULT_TWO_GAPS = 4'h4;
    localparam logic [3:0] BRT_FAULT_ARB_GAP = 4'h5;
    localparam logic [3:0] BRT_FAULT_ID_MISMATCH = 4'h6;
    localparam logic [3:0] BRT_FAULT_PAIR_ORDER = 4'h7;
    localparam logic [3:0] BRT_FAULT_LEAD_BITS = 4'h8;
    localparam logic [3:0] BRT_FAULT_GAP_COUNT = 4'hf;

    // ************************************************************
    // Interrupt status bit positions.
    // ************************************************************
    localparam int BRT_IRQ_BUS_RESET = 0;
    localparam int BRT_IRQ_FAULT = 1;
    localparam int BRT_IRQ_RESP_TIMEOUT = 2;
    localparam int BRT_IRQ_RETRY_EXHAUSTED = 3;
    localparam int BRT_IRQ_W = 4;

    // ************************************************************
    // Timing: one isochronous cycle in clock periods.
    // ************************************************************
    localparam int BRT_CLK_PERIOD_NS = 20;
    localparam int BRT_ISO_CYCLE_NS = 125000;
    localparam int BRT_ISO_CYCLE_CLKS = BRT_ISO_CYCLE_NS / BRT_CLK_PERIOD_NS;

    // Retry engine states.
    typedef enum logic [2:0]
    {
        BRT_RETRY_IDLE = 3'b001,
        BRT_RETRY_GAP = 3'b010,
        BRT_RETRY_ACK = 3'b100
    } brt_retry_state_type;

endpackage

// file: brt_regs.sv
`timescale 1ns/100ps
`default_nettype none
module brt_regs
    import brt_pkg::*;
#(
    parameter int ISO_CYCLE_CLKS = BRT_ISO_CYCLE_CLKS
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic bus_reset_done,
    input wire logic [9:0] new_bus_index,
    input wire logic [5:0] new_node_index,
    input wire logic [3:0] new_fault,
    input wire logic [5:0] new_node_total,
    input wire logic [5:0] new_rm_node,
    output logic [9:0] bus_index,
    output logic [5:0] local_node_index,
    input wire logic resp_start,
    input wire logic resp_received,
    output logic resp_timeout,
    input wire logic tx_ack_valid,
    input wire logic tx_ack_busy,
    output logic retransmit_req,
    output logic retry_exhausted,
    input wire logic fetch_req,
    output logic fetch_go,
    output logic irq
);
    // ************************************************************
    // Register storage and bus decode.
    // ************************************************************
    logic [31:0] status_reg;
    logic [31:0] limits_reg;
    logic [BRT_IRQ_W-1:0] irq_status_reg;
    logic [BRT_IRQ_W-1:0] irq_mask_reg;
    logic [31:0] prdata_reg;
    logic [BRT_IRQ_W-1:0] irq_event;
    logic setup_phase;
    logic wr_access;
    logic hit_status;
    logic hit_limits;
    logic hit_irq_status;
    logic hit_irq_mask;
    logic mapped;

    assign setup_phase = psel && !penable;
    assign wr_access = psel && penable && pwrite;
    assign hit_status = (paddr == BRT_BUS_RESET_STATUS_OFF);
    assign hit_limits = (paddr == BRT_TIME_LIMITS_OFF);
    assign hit_irq_status = (paddr == BRT_IRQ_STATUS_OFF);
    assign hit_irq_mask = (paddr == BRT_IRQ_MASK_OFF);
    assign mapped = hit_status || hit_limits || hit_irq_status
        || hit_irq_mask;

    // Zero wait states; unmapped addresses fail in the access phase.
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_reg;

    // ************************************************************
    // Field views of the two registers.
    // ************************************************************
    logic [15:0] wait_limit;
    logic [7:0] retry_gap;
    logic [3:0] retry_limit;
    logic [3:0] fetch_delay;

    assign bus_index = status_reg[BRT_BUS_INDEX_LSB +: 10];
    assign local_node_index = status_reg[BRT_NODE_INDEX_LSB +: 6];
    assign wait_limit = limits_reg[BRT_WAIT_LIMIT_LSB +: 16];
    assign retry_gap = limits_reg[BRT_RETRY_GAP_LSB +: 8];
    assign retry_limit = limits_reg[BRT_RETRY_LIMIT_LSB +: 4];
    assign fetch_delay = limits_reg[BRT_FETCH_DELAY_LSB +: 4];

    // Read data is latched in the setup phase, stable in the access.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_reg <= '0;
        else if (setup_phase)
        begin
            unique case (1'b1)
                hit_status: prdata_reg <= status_reg;
                hit_limits: prdata_reg <= limits_reg;
                hit_irq_status: prdata_reg <= 32'(irq_status_reg);
                hit_irq_mask: prdata_reg <= 32'(irq_mask_reg);
                default: prdata_reg <= '0;
            endcase
        end
    end

    // power-up value, other bits kept
    // The completion strobe wins over a simultaneous host write of the
    // bus index, so software must rewrite it after each bus reset.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            status_reg <= BRT_BUS_RESET_STATUS_RST;
        else if (bus_reset_done)
        begin
            status_reg[BRT_BUS_INDEX_LSB +: 10] <= new_bus_index;
            status_reg[BRT_NODE_INDEX_LSB +: 6] <= new_node_index;
            status_reg[BRT_FAULT_LSB +: 4] <= new_fault;
            status_reg[BRT_NODE_TOTAL_LSB +: 6] <= new_node_total;
            status_reg[BRT_RM_NODE_LSB +: 6] <= new_rm_node;
        end
        else if (wr_access && hit_status)
            status_reg[BRT_BUS_INDEX_LSB +: 10] <=
                pwdata[BRT_BUS_INDEX_LSB +: 10];
    end

    // power-up value, untouched by bus reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            limits_reg <= BRT_TIME_LIMITS_RST;
        else if (wr_access && hit_limits)
            limits_reg <= pwdata;
    end

    // ************************************************************
    // Interrupt status and mask.
    // ************************************************************
    logic fault_seen;

    // any nonzero code flags a fault
    assign fault_seen = bus_reset_done && (new_fault != BRT_FAULT_NONE);

    always_comb
    begin
        irq_event = '0;
        irq_event[BRT_IRQ_BUS_RESET] = bus_reset_done;
        irq_event[BRT_IRQ_FAULT] = fault_seen;
        irq_event[BRT_IRQ_RESP_TIMEOUT] = resp_timeout;
        irq_event[BRT_IRQ_RETRY_EXHAUSTED] = retry_exhausted;
    end

    // Write one to clear; a new event in the same cycle wins.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_status_reg <= '0;
        else if (wr_access && hit_irq_status)
            irq_status_reg <= (irq_status_reg & ~pwdata[BRT_IRQ_W-1:0])
                | irq_event;
        else
            irq_status_reg <= irq_status_reg | irq_event;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_mask_reg <= BRT_IRQ_MASK_RST;
        else if (wr_access && hit_irq_mask)
            irq_mask_reg <= pwdata[BRT_IRQ_W-1:0];
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    // ************************************************************
    // Cycle tick and the three delay timers.
    // ************************************************************
    logic iso_tick;
    logic resp_busy;
    logic gap_start;
    logic gap_expired;
    logic fetch_busy;
    logic [16:0] resp_load;

    brt_iso_tick #(.CYCLE_CLKS(ISO_CYCLE_CLKS)) u_tick
    (
        .pclk(pclk),
        .presetn(presetn),
        .tick(iso_tick)
    );

    // expire only once the limit is exceeded
    // The tick is free running, so the first counted cycle may be short.
    assign resp_load = {1'b0, wait_limit} + 17'h00001;

    brt_cycle_timer #(.W(17)) u_resp_timer
    (
        .pclk(pclk),
        .presetn(presetn),
        .start(resp_start),
        .abort(resp_received),
        .load(resp_load),
        .tick(iso_tick),
        .busy(resp_busy),
        .expired(resp_timeout)
    );

    // gap between busy ack and retry
    brt_cycle_timer #(.W(8)) u_gap_timer
    (
        .pclk(pclk),
        .presetn(presetn),
        .start(gap_start),
        .abort(1'b0),
        .load(retry_gap),
        .tick(iso_tick),
        .busy(),
        .expired(gap_expired)
    );

    // delay before the command block fetch
    brt_cycle_timer #(.W(4)) u_fetch_timer
    (
        .pclk(pclk),
        .presetn(presetn),
        .start(fetch_req),
        .abort(1'b0),
        .load(fetch_delay),
        .tick(iso_tick),
        .busy(fetch_busy),
        .expired(fetch_go)
    );

    // ************************************************************
    // Busy retry engine.
    // ************************************************************
    brt_retry_state_type state_reg;
    logic [3:0] tries_reg;
    logic retx_reg;
    logic exhausted_reg;
    logic busy_ack;

    assign busy_ack = tx_ack_valid && tx_ack_busy;
    // zero limit never starts a gap
    assign gap_start = busy_ack && (retry_limit != 4'h0)
        && ((state_reg == BRT_RETRY_IDLE)
        || (state_reg == BRT_RETRY_ACK && tries_reg < retry_limit));

    // retry up to the limit, stop early
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= BRT_RETRY_IDLE;
            tries_reg <= 4'h0;
            retx_reg <= 1'b0;
            exhausted_reg <= 1'b0;
        end
        else
        begin
            retx_reg <= 1'b0;
            exhausted_reg <= 1'b0;
            unique case (state_reg)
                BRT_RETRY_IDLE:
                begin
                    tries_reg <= 4'h0;
                    if (gap_start)
                        state_reg <= BRT_RETRY_GAP;
                    else if (busy_ack)
                        exhausted_reg <= 1'b1;
                end
                BRT_RETRY_GAP:
                begin
                    if (gap_expired)
                    begin
                        retx_reg <= 1'b1;
                        tries_reg <= tries_reg + 4'h1;
                        state_reg <= BRT_RETRY_ACK;
                    end
                end
                BRT_RETRY_ACK:
                begin
                    if (gap_start)
                        state_reg <= BRT_RETRY_GAP;
                    else if (tx_ack_valid)
                    begin
                        exhausted_reg <= tx_ack_busy;
                        state_reg <= BRT_RETRY_IDLE;
                    end
                end
            endcase
        end
    end

    assign retransmit_req = retx_reg;
    assign retry_exhausted = exhausted_reg;

    // ************************************************************
    // Checks of the register bank and timers.
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_bus_reload: assert property (
        bus_reset_done |=> bus_index == $past(new_bus_index))
        else $error("bus index not reloaded after bus reset");
    a_node_load: assert property (
        bus_reset_done ##1 !bus_reset_done[*2]
        |-> local_node_index == $past(new_node_index, 2))
        else $error("node index lost after bus reset");
    a_fault_load: assert property (
        bus_reset_done |=> status_reg[BRT_FAULT_LSB +: 4] == $past(new_fault))
        else $error("self-ID check result not captured");
    a_fault_flag: assert property (
        bus_reset_done && new_fault != BRT_FAULT_NONE
        |=> irq_status_reg[BRT_IRQ_FAULT])
        else $error("nonzero fault code did not raise status");
    a_topo_load: assert property (
        bus_reset_done |=>
        status_reg[BRT_NODE_TOTAL_LSB +: 6] == $past(new_node_total)
        && status_reg[BRT_RM_NODE_LSB +: 6] == $past(new_rm_node))
        else $error("node total or manager id not loaded");
    a_status_hold: assert property (
        !bus_reset_done && !(wr_access && hit_status)
        |=> $stable(status_reg))
        else $error("bus reset status changed without cause");
    a_limits_hold: assert property (
        !(wr_access && hit_limits) |=> $stable(limits_reg))
        else $error("time limits changed without a write");
    a_zero_limit: assert property (
        state_reg == BRT_RETRY_IDLE && busy_ack && retry_limit == 4'h0
        |=> retry_exhausted ##1 !retransmit_req)
        else $error("busied packet retried with zero limit");
    a_retry_bound: assert property (
        state_reg == BRT_RETRY_ACK |-> tries_reg <= retry_limit)
        else $error("retries exceeded the retry limit");
    a_retry_gap: assert property (
        retransmit_req |-> $past(gap_expired))
        else $error("retransmission without the retry gap");
    a_fetch_zero: assert property (
        fetch_req && fetch_delay == 4'h0 && !fetch_busy |-> ##2 fetch_go)
        else $error("zero fetch delay did not fetch in two cycles");
    a_resp_abort: assert property (
        resp_received && !resp_start |=> ##1 !resp_timeout)
        else $error("timeout after the response arrived");

    c_bus_reset_fault: cover property (bus_reset_done && fault_seen);
    c_resp_timeout: cover property (resp_timeout);
    c_retry_then_ok: cover property (retransmit_req ##[1:50] tx_ack_valid
        && !tx_ack_busy);
    c_irq_clear: cover property (irq ##1 !irq);
endmodule // brt_regs
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import brt_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] st = 4'h0;
    logic busy = 1'b0;
    logic go_rst = 1'b0;
    logic [31:0] topo = 32'h0;
    wire logic [31:0] prdata, topo_out;
    wire logic pready, pslverr, brd, ack_v, ack_b, irq;
    wire logic [9:0] bus_index;
    wire logic [5:0] node_index;
    wire logic [3:0] pul;
    logic [32:0] exp_q[$];
    int fails = 0;
    int cmp_count = 0;
    int cnt[4];
    int first[4];

    // A short tick keeps every timer run to a few dozen clocks.
    brt_regs #(.ISO_CYCLE_CLKS(4)) u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus_reset_done(brd),
        .new_bus_index(topo_out[31:22]), .new_node_index(topo_out[21:16]),
        .new_fault(topo_out[15:12]), .new_node_total(topo_out[11:6]),
        .new_rm_node(topo_out[5:0]), .bus_index(bus_index),
        .local_node_index(node_index), .resp_start(st[0]),
        .resp_received(st[1]), .resp_timeout(pul[2]),
        .tx_ack_valid(ack_v), .tx_ack_busy(ack_b),
        .retransmit_req(pul[0]), .retry_exhausted(pul[1]),
        .fetch_req(st[2]), .fetch_go(pul[3]), .irq(irq));

    brt_node_model u_node (.pclk(pclk), .presetn(presetn),
        .go_reset(go_rst), .topo(topo), .go_ack(st[3]), .busy(busy),
        .bus_reset_done(brd), .topo_out(topo_out), .tx_ack_valid(ack_v),
        .tx_ack_busy(ack_b));

    always #10 pclk = ~pclk;

    task automatic chk(input string nm, input logic [32:0] e,
        input logic [32:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Read results are taken at the edge that completes the access.
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite
            && exp_q.size() > 0)
            chk("prdata", exp_q.pop_front(), {pslverr, prdata});
    end

    // One APB transfer; the request holds until pready is seen high.
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic kick(input logic [3:0] m);
        @(posedge pclk);
        st <= m;
        @(posedge pclk);
        st <= 4'h0;
    endtask

    // Counts output pulses and the cycle of the first of each kind.
    task automatic watch(input int cyc);
        for (int i = 0; i < 4; i++)
        begin
            cnt[i] = 0;
            first[i] = -1;
        end
        for (int c = 1; c <= cyc; c++)
        begin
            @(negedge pclk);
            for (int i = 0; i < 4; i++)
                if (pul[i] === 1'b1)
                begin
                    if (cnt[i] == 0)
                        first[i] = c;
                    cnt[i]++;
                end
        end
    endtask

    task automatic brst(input logic [31:0] t);
        @(posedge pclk);
        go_rst <= 1'b1;
        topo <= t;
        @(posedge pclk);
        go_rst <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    task automatic ack(input logic b, input int rt, input int ex);
        busy <= b;
        kick(4'h8);
        watch(20);
        chk("retransmit", rt, cnt[0]);
        chk("exhausted", ex, cnt[1]);
    endtask

    // The watchdog allows more than thirty times the expected run length.
    initial
    begin
        repeat (20000) @(posedge pclk);
        fails++;
        final_report;
    end

    initial
    begin
        logic [31:0] v;
        logic [31:0] t;
        void'($urandom(34));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(BRT_BUS_RESET_STATUS_OFF, 33'h0ffff003f);
        rd(BRT_TIME_LIMITS_OFF, 33'h0032008e0);
        rd(BRT_IRQ_STATUS_OFF, 33'h0);
        rd(12'h0fc, 33'h100000000);
        $display("test reset values done");
        v = $urandom;
        apb(1'b1, BRT_BUS_RESET_STATUS_OFF, v);
        rd(BRT_BUS_RESET_STATUS_OFF, {1'b0, v[31:22], 22'h3f003f});
        v = $urandom;
        apb(1'b1, BRT_TIME_LIMITS_OFF, v);
        // Every fault code; the next bus reset follows each one.
        for (int f = 0; f < 16; f++)
        begin
            t = $urandom;
            t[15:12] = f[3:0];
            brst(t);
            rd(BRT_BUS_RESET_STATUS_OFF, {1'b0, t});
            chk("bus_index", t[31:22], bus_index);
            chk("node_index", t[21:16], node_index);
            rd(BRT_IRQ_STATUS_OFF, {31'h0, f != 0, 1'b1});
            apb(1'b1, BRT_IRQ_STATUS_OFF, 32'hf);
        end
        rd(BRT_TIME_LIMITS_OFF, {1'b0, v});
        $display("test bus reset done");
        apb(1'b1, BRT_IRQ_MASK_OFF, 32'h1);
        brst(32'h0);
        chk("irq", 1'b1, irq);
        apb(1'b1, BRT_IRQ_STATUS_OFF, 32'h1);
        @(negedge pclk);
        chk("irq", 1'b0, irq);
        apb(1'b1, BRT_IRQ_MASK_OFF, 32'h0);
        brst(32'h0);
        chk("irq", 1'b0, irq);
        apb(1'b1, BRT_IRQ_STATUS_OFF, 32'hf);
        $display("test interrupt done");
        // Wait limit 2, gap 1, retry limit 2, fetch delay 3.
        apb(1'b1, BRT_TIME_LIMITS_OFF, 32'h00020123);
        kick(4'h4);
        watch(30);
        chk("fetch_go", 1, cnt[3]);
        chk("fetch_lat", 1, first[3] >= 10 && first[3] <= 18);
        kick(4'h1);
        watch(30);
        chk("timeout", 1, cnt[2]);
        chk("timeout_lat", 1, first[2] >= 9 && first[2] <= 16);
        kick(4'h1);
        kick(4'h2);
        watch(30);
        chk("timeout", 0, cnt[2]);
        ack(1'b1, 1, 0);
        ack(1'b1, 1, 0);
        ack(1'b1, 0, 1);
        ack(1'b1, 1, 0);
        ack(1'b0, 0, 0);
        apb(1'b1, BRT_TIME_LIMITS_OFF, 32'h00020100);
        ack(1'b1, 0, 1);
        kick(4'h4);
        watch(10);
        chk("fetch_lat", 2, first[3]);
        rd(BRT_IRQ_STATUS_OFF, 33'h00000000c);
        $display("test timers done");
        final_report;
    end
endmodule // tb_top
`default_nettype wire
